// ### timer_map.svh
// Register offsets, field positions, reset values for the timer counter.
// Included by trig_if, trig_detect, the counter and the bench; definitions only.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define CNT_W 16
`define TRIG_N 4
`define EVT_N 5
`define SRC_W 3
`define EDGE_W 2
`define OFF_EN_SET 12'h000
`define OFF_EN_CLR 12'h004
`define OFF_CMD 12'h008
`define OFF_CTRL 12'h00c
`define OFF_STATUS 12'h010
`define OFF_COUNT 12'h014
`define OFF_CMP 12'h018
`define OFF_CMP_SH 12'h01c
`define OFF_TOP 12'h020
`define OFF_TOP_SH 12'h024
`define OFF_TRSEL 12'h028
`define OFF_TREDGE 12'h02c
`define OFF_INTR 12'h030
`define OFF_INTR_SET 12'h034
`define OFF_INTR_MASK 12'h038
`define OFF_INTR_MSKD 12'h03c
`define CTL_SWAP 0
`define CTL_PSC_LO 8
`define CTL_PSC_HI 10
`define CTL_DIR_LO 16
`define CTL_DIR_HI 17
`define CTL_SINGLE 18
`define CTL_MODE_LO 24
`define CTL_MODE_HI 26
`define MODE_TIMER 3'h0
`define CMD_RELOAD 0
`define CMD_START 1
`define CMD_STOP 2
`define EVT_RELOAD 0
`define EVT_START 1
`define EVT_STOP 2
`define EVT_COUNT 3
`define EVT_CAPTURE 4
`define INTR_TC 0
`define INTR_CC 1
`define CTRL_RST 32'h0000_0000
`define TOP_RST 16'hffff
`define TRSEL_RST 15'h0200
`define TREDGE_RST 10'h0c0
`endif

// ### timer_pkg.sv
// Types shared by the timer counter modules.
// Assumes nothing beyond the map header.
package timer_pkg;
   typedef enum logic [1:0] {DIR_UP = 2'b00, DIR_DOWN = 2'b01,
      DIR_UPDN_A = 2'b10, DIR_UPDN_B = 2'b11} dir_sel_t;
   typedef enum logic [1:0] {ST_OFF = 2'b00, ST_STOP = 2'b01,
      ST_RUN = 2'b11} run_state_t;
   typedef enum logic [1:0] {EDGE_RISE = 2'b00, EDGE_FALL = 2'b01,
      EDGE_BOTH = 2'b10, EDGE_LEVEL = 2'b11} edge_t;
endpackage

// ### trig_if.sv
// Trigger selection and detected events between counter and detector.
// Both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
interface trig_if;
   logic [`EVT_N*`SRC_W-1:0] src_sel;
   logic [`EVT_N*`EDGE_W-1:0] edge_sel;
   logic [`EVT_N-1:0] evt;
   modport det (input src_sel, input edge_sel, output evt);
   modport ctl (output src_sel, output edge_sel, input evt);
endinterface
`default_nettype wire

// ### trig_detect.sv
// Synchronises trigger pins and detects the selected edge per event.
// Assumes TRIG_IN is asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
module trig_detect
   import timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`TRIG_N-1:0] trig_in,
   trig_if.det tif
);
   logic [`TRIG_N-1:0] sync1_reg;
   logic [`TRIG_N-1:0] sync2_reg;
   logic [`EVT_N-1:0] prev_reg;
   logic [`EVT_N-1:0] lvl;
   logic [`TRIG_N+1:0] src_vec;

   // Source 0 is constant low, 1 constant high, 2 to 5 are the pins, 6 and 7 read low
   assign src_vec = {sync2_reg, 1'b1, 1'b0};

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end
      else
      begin
         sync1_reg <= trig_in;
         sync2_reg <= sync1_reg;
         prev_reg <= lvl;
      end
   end

   genvar i;
   generate
      for (i = 0; i < `EVT_N; i++)
      begin : g_evt
         wire [`SRC_W-1:0] sel = tif.src_sel[i*`SRC_W +: `SRC_W];
         wire [`EDGE_W-1:0] edg = tif.edge_sel[i*`EDGE_W +: `EDGE_W];
         assign lvl[i] = (sel < 3'd6) ? src_vec[sel] : 1'b0;
         assign tif.evt[i] = (edg == EDGE_RISE) ? lvl[i] & ~prev_reg[i] :
            (edg == EDGE_FALL) ? ~lvl[i] & prev_reg[i] :
            (edg == EDGE_BOTH) ? lvl[i] ^ prev_reg[i] : lvl[i];
      end
   endgenerate
endmodule // trig_detect
`default_nettype wire

// ### pulse_stretch.sv
// Widens one-cycle counter events to two-cycle trigger outputs.
// Assumes inputs are single-cycle pulses on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] pulse_in,
   output logic [3:0] pulse_out
);
   logic [3:0] first_reg;
   logic [3:0] out_reg;

   assign pulse_out = out_reg;

   genvar k;
   generate
      for (k = 0; k < 4; k++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               first_reg[k] <= 1'b0;
               out_reg[k] <= 1'b0;
            end
            else
            begin
               first_reg[k] <= pulse_in[k];
               out_reg[k] <= pulse_in[k] | first_reg[k]; // RULE_16
            end
         end
         pulse_two_a: assert property (@(posedge clk) disable iff (!rst_b)
            $rose(out_reg[k]) |-> out_reg[k] [*2]) // RULE_16
            else $error("Trigger pulse shorter than two cycles");
      end
   endgenerate
endmodule // pulse_stretch
`default_nettype wire

// ### timer_mode_counter.sv
// Timer mode of a general counter unit with an APB register slave.
// Assumes APB master on CORE_CLK; TRIG_IN pins are asynchronous.
// Operation
// RULE_01: Count stays between zero and top_value in the chosen direction.
// RULE_02: compare_hit when a running count leaves compare_value.
// RULE_03: Reload loads 0, top_value or 1 per direction and starts.
// RULE_04: Start on stopped counter keeps count, sets up/down direction.
// RULE_05: Start while running is ignored.
// RULE_06: Stop halts the counter; count holds while stopped.
// RULE_07: Count changes by one only on detected count events.
// RULE_08: Optional prescaler gates counting to active cycles.
// RULE_09: Single-run stops after one period on the terminal wrap.
// RULE_10: single_run bit 18 selects continuous or single-run.
// RULE_11: compare_swap_enable exchanges compare registers on a hit.
// RULE_12: Ranges: 0..top up, top..0 down, 1..top..0 up/down.
// RULE_13: zero_wrap_event when decrementing away from zero.
// RULE_14: top_wrap_event when incrementing away from top_value.
// RULE_15: terminal_event derived from wrap events per direction.
// RULE_16: Trigger output pulses last two system clocks.
// RULE_17: Only top_value limits the period; shadow is ignored.
// RULE_18: Software must not write the count while running.
// RULE_19: Reload waits for a cycle with the count event high.
// RULE_20: Function field 26:24 equal 000 selects timer operation.
// RULE_21: Direction comes from control bits 17:16.
// RULE_22: Software disables, configures, enables, then starts.
// RULE_23: Direction codes 00 up, 01 down, 10/11 up/down variants.
// RULE_24: Interrupt bits: 0 terminal, 1 compare; write one clears.
// RULE_25: Capture input ignored; wave outputs held inactive.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
module timer_mode_counter
   import timer_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [`TRIG_N-1:0] TRIG_IN,
   input wire logic CAPTURE_IN,
   output logic CC_HIT_OUT,
   output logic ZERO_WRAP_OUT,
   output logic TOP_WRAP_OUT,
   output logic TERMINAL_OUT,
   output logic IRQ,
   output logic WAVE_OUT,
   output logic WAVE_OUT_INV
);
   trig_if tif ();

   logic en_reg;
   logic [31:0] ctl_reg;
   logic [`CNT_W-1:0] cnt_reg, cnt_next;
   logic [`CNT_W-1:0] cc_reg, cc_next;
   logic [`CNT_W-1:0] ccb_reg, ccb_next;
   logic [`CNT_W-1:0] top_reg, topb_reg;
   logic [`EVT_N*`SRC_W-1:0] trsel_reg;
   logic [`EVT_N*`EDGE_W-1:0] tredge_reg;
   logic [1:0] intr_reg, intr_next, mask_reg;
   logic [7:0] presc_reg;
   logic dir_down_reg, dir_down_next;
   logic rld_pend_reg, start_pend_reg, stop_pend_reg, cnt_pend_reg;
   run_state_t state_reg, state_next;
   logic [3:0] evt_out;

   // APB decode: zero wait states, error on unmapped words
   wire acc = PSEL & PENABLE;
   wire wr = acc & PWRITE;
   wire a_enset = PADDR == `OFF_EN_SET;
   wire a_enclr = PADDR == `OFF_EN_CLR;
   wire a_cmd = PADDR == `OFF_CMD;
   wire a_ctrl = PADDR == `OFF_CTRL;
   wire a_stat = PADDR == `OFF_STATUS;
   wire a_cnt = PADDR == `OFF_COUNT;
   wire a_cc = PADDR == `OFF_CMP;
   wire a_ccb = PADDR == `OFF_CMP_SH;
   wire a_top = PADDR == `OFF_TOP;
   wire a_topb = PADDR == `OFF_TOP_SH;
   wire a_trsel = PADDR == `OFF_TRSEL;
   wire a_tredge = PADDR == `OFF_TREDGE;
   wire a_intr = PADDR == `OFF_INTR;
   wire a_iset = PADDR == `OFF_INTR_SET;
   wire a_imask = PADDR == `OFF_INTR_MASK;
   wire a_imskd = PADDR == `OFF_INTR_MSKD;
   wire mapped = a_enset | a_enclr | a_cmd | a_ctrl | a_stat | a_cnt |
      a_cc | a_ccb | a_top | a_topb | a_trsel | a_tredge | a_intr |
      a_iset | a_imask | a_imskd;
   wire [`CNT_W-1:0] wdat = PWDATA[`CNT_W-1:0];
   wire [1:0] intr_masked = intr_reg & mask_reg;

   assign PREADY = 1'b1;
   assign PSLVERR = acc & ~mapped;
   assign PRDATA =
      (a_enset | a_enclr) ? {31'h0, en_reg} :
      a_ctrl ? ctl_reg :
      a_stat ? {30'h0, dir_down_reg, state_reg == ST_RUN} :
      a_cnt ? {16'h0, cnt_reg} :
      a_cc ? {16'h0, cc_reg} :
      a_ccb ? {16'h0, ccb_reg} :
      a_top ? {16'h0, top_reg} :
      a_topb ? {16'h0, topb_reg} :
      a_trsel ? {17'h0, trsel_reg} :
      a_tredge ? {22'h0, tredge_reg} :
      (a_intr | a_iset) ? {30'h0, intr_reg} :
      a_imask ? {30'h0, mask_reg} :
      a_imskd ? {30'h0, intr_masked} : 32'h0;

   // Control fields
   wire swap_en = ctl_reg[`CTL_SWAP];
   wire [2:0] psc_sel = ctl_reg[`CTL_PSC_HI:`CTL_PSC_LO];
   wire [1:0] dir_bits = ctl_reg[`CTL_DIR_HI:`CTL_DIR_LO]; // RULE_21
   wire single = ctl_reg[`CTL_SINGLE]; // RULE_10
   wire timer_mode =
      ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO] == `MODE_TIMER; // RULE_20
   dir_sel_t dir_sel;
   assign dir_sel = dir_sel_t'(dir_bits); // RULE_23
   wire updn = dir_sel == DIR_UPDN_A || dir_sel == DIR_UPDN_B;

   // Firmware commands are one-cycle strobes on a write
   wire [2:0] cmd = (wr & a_cmd) ? PWDATA[2:0] : 3'h0;

   // Prescaler: active cycle every 2**psc_sel core clocks
   wire [7:0] psc_mask = 8'((9'h001 << psc_sel) - 9'h001);
   wire tick = (presc_reg & psc_mask) == psc_mask; // RULE_08
   wire live = en_reg & timer_mode;

   // Pending start, stop and count triggers survive until the next active cycle, reload until it is taken
   wire cnt_now = cnt_pend_reg | tif.evt[`EVT_COUNT]; // RULE_07
   wire rld_now = rld_pend_reg | tif.evt[`EVT_RELOAD] | cmd[`CMD_RELOAD];
   wire start_now = start_pend_reg | tif.evt[`EVT_START] |
      cmd[`CMD_START];
   wire stop_now = stop_pend_reg | tif.evt[`EVT_STOP] | cmd[`CMD_STOP];
   wire act = live & tick;
   wire reload_go = act & cnt_now & rld_now; // RULE_19
   wire stop_go = act & stop_now & ~reload_go; // RULE_06
   wire start_go = act & start_now & ~reload_go & ~stop_now &
      (state_reg == ST_STOP); // RULE_05
   wire adv = act & cnt_now & ~reload_go & ~stop_now &
      (state_reg == ST_RUN); // RULE_07

   // Count arithmetic
   wire is_top = cnt_reg == top_reg; // RULE_17
   wire is_zero = cnt_reg == '0;
   wire cnt_up = (dir_sel == DIR_UP) | (updn & ~dir_down_reg);
   wire top_hit = adv & cnt_up & is_top; // RULE_14
   wire zero_hit = adv & ~cnt_up & is_zero; // RULE_13
   wire cc_hit = adv & (cnt_reg == cc_reg); // RULE_02
   wire term = (dir_sel == DIR_UP) ? top_hit :
      (dir_sel == DIR_UPDN_B) ? (top_hit | zero_hit) : zero_hit; // RULE_15
   wire single_end = single &
      ((dir_sel == DIR_UP) ? top_hit : zero_hit); // RULE_09
   wire [`CNT_W-1:0] inc = cnt_reg + 16'h0001;
   wire [`CNT_W-1:0] dec = cnt_reg - 16'h0001;
   // Up/down turns at either end instead of wrapping
   wire [`CNT_W-1:0] step =
      (cnt_up & is_top) ? (updn ? dec : 16'h0000) :
      (~cnt_up & is_zero) ? (updn ? inc : top_reg) :
      cnt_up ? inc : dec; // RULE_01 RULE_12
   wire [`CNT_W-1:0] load_val = (dir_sel == DIR_UP) ? 16'h0000 :
      (dir_sel == DIR_DOWN) ? top_reg : 16'h0001; // RULE_03
   wire wr_cnt = wr & a_cnt; // RULE_18
   assign cnt_next = wr_cnt ? wdat : reload_go ? load_val :
      adv ? step : cnt_reg; // RULE_06

   always_comb
   begin
      dir_down_next = dir_down_reg;
      if (reload_go)
         dir_down_next = dir_sel == DIR_DOWN; // RULE_03
      else if (start_go && !updn)
         dir_down_next = dir_sel == DIR_DOWN; // RULE_04
      else if (top_hit && updn)
         dir_down_next = 1'b1; // RULE_12
      else if (zero_hit && updn)
         dir_down_next = 1'b0; // RULE_12
   end

   // Hardware swap beats a software write in the same cycle
   wire swap = cc_hit & swap_en; // RULE_11
   assign cc_next = swap ? ccb_reg : (wr & a_cc) ? wdat : cc_reg;
   assign ccb_next = swap ? cc_reg : (wr & a_ccb) ? wdat : ccb_reg;

   // Events set request bits even in the cycle software clears them
   wire [1:0] ev_req = {cc_hit, term};
   wire [1:0] clr = (wr & a_intr) ? PWDATA[1:0] : 2'h0;
   wire [1:0] sw_set = (wr & a_iset) ? PWDATA[1:0] : 2'h0;
   assign intr_next = (intr_reg & ~clr) | sw_set | ev_req; // RULE_24

   always_comb
   begin
      case (state_reg)
         ST_OFF: state_next = live ? ST_STOP : ST_OFF;
         ST_STOP: state_next = (reload_go | start_go) ? ST_RUN : ST_STOP;
         ST_RUN: state_next = (stop_go | (adv & single_end)) ? ST_STOP :
            ST_RUN; // RULE_09
         default: state_next = ST_OFF;
      endcase
      if (!live)
         state_next = ST_OFF;
      else if (reload_go)
         state_next = ST_RUN; // RULE_03
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_reg <= ST_OFF;
         cnt_reg <= '0;
         dir_down_reg <= 1'b0;
         presc_reg <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         dir_down_reg <= dir_down_next;
         presc_reg <= live ? presc_reg + 8'h01 : 8'h00;
      end
   end

   // Start, stop and count drop at an active cycle, a reload once taken; all drop when not live, otherwise kept
   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rld_pend_reg <= 1'b0;
         start_pend_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
         cnt_pend_reg <= 1'b0;
      end
      else
      begin
         rld_pend_reg <= live & rld_now & ~reload_go; // RULE_19
         start_pend_reg <= live & start_now & ~act;
         stop_pend_reg <= live & stop_now & ~act;
         cnt_pend_reg <= live & cnt_now & ~act;
      end
   end

   // Enable via separate set and clear words
   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
         en_reg <= 1'b0;
      else if (wr && a_enset && PWDATA[0])
         en_reg <= 1'b1; // RULE_22
      else if (wr && a_enclr && PWDATA[0])
         en_reg <= 1'b0; // RULE_22
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ctl_reg <= `CTRL_RST;
         top_reg <= `TOP_RST;
         topb_reg <= `TOP_RST;
         trsel_reg <= `TRSEL_RST;
         tredge_reg <= `TREDGE_RST;
         mask_reg <= 2'h0;
      end
      else if (wr)
      begin
         if (a_ctrl) ctl_reg <= PWDATA;
         if (a_top) top_reg <= wdat;
         if (a_topb) topb_reg <= wdat;
         if (a_trsel) trsel_reg <= PWDATA[`EVT_N*`SRC_W-1:0];
         if (a_tredge) tredge_reg <= PWDATA[`EVT_N*`EDGE_W-1:0];
         if (a_imask) mask_reg <= PWDATA[1:0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         cc_reg <= '0;
         ccb_reg <= '0;
         intr_reg <= 2'h0;
      end
      else
      begin
         cc_reg <= cc_next;
         ccb_reg <= ccb_next;
         intr_reg <= intr_next;
      end
   end

   assign tif.src_sel = trsel_reg;
   assign tif.edge_sel = tredge_reg;

   trig_detect u_trig (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .trig_in(TRIG_IN),
      .tif(tif)
   );

   pulse_stretch u_stretch (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .pulse_in({term, top_hit, zero_hit, cc_hit}),
      .pulse_out(evt_out)
   );

   assign {TERMINAL_OUT, TOP_WRAP_OUT, ZERO_WRAP_OUT, CC_HIT_OUT} =
      evt_out; // RULE_16
   assign IRQ = |intr_masked; // RULE_24
   // Capture input is not used in this mode
   assign WAVE_OUT = 1'b0; // RULE_25
   assign WAVE_OUT_INV = 1'b0; // RULE_25

   default clocking dc @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);

   sequence reload_seq;
      reload_go && dir_sel == DIR_UP && !wr_cnt;
   endsequence

   reload_up_a: assert property (reload_seq |=> // RULE_03
      cnt_reg == 16'h0000 && state_reg == ST_RUN)
      else $error("Reload in up mode did not load zero and run");
   count_range_a: assert property ( // RULE_01
      adv && !wr_cnt && cnt_reg <= top_reg && !(wr && a_top)
      |=> cnt_reg <= top_reg)
      else $error("Count left the range zero to top");
   stop_hold_a: assert property ( // RULE_06
      state_reg != ST_RUN && !reload_go && !wr_cnt |=> $stable(cnt_reg))
      else $error("Count changed while stopped");
   start_ignore_a: assert property ( // RULE_05
      state_reg == ST_RUN && start_now && act && !reload_go && !stop_now
      && !updn && !single_end
      |=> $stable(dir_down_reg) && state_reg == ST_RUN)
      else $error("Start while running had an effect");
   single_stop_a: assert property ( // RULE_09
      single && dir_sel == DIR_UP && top_hit |=> state_reg == ST_STOP)
      else $error("Single run did not stop on top wrap");
   cmp_swap_a: assert property ( // RULE_11
      swap && !(wr && (a_cc || a_ccb))
      |=> cc_reg == $past(ccb_reg) && ccb_reg == $past(cc_reg))
      else $error("Compare registers not exchanged on hit");
   turn_down_a: assert property ( // RULE_12
      updn && top_hit |=> dir_down_reg ##1 (!adv || cnt_up == 1'b0))
      else $error("Up/down counter did not turn at top");
   irq_set_a: assert property ( // RULE_24
      term |=> intr_reg[`INTR_TC])
      else $error("Terminal event did not set request bit");
   term_out_a: assert property ( // RULE_15
      term |=> ##1 TERMINAL_OUT)
      else $error("Terminal event not on trigger output");
endmodule // timer_mode_counter
`default_nettype wire

// ### trig_src.sv
// Trigger source model: drives the timer's trigger pins.
// Assumes the bench raises fire for one core clock per wanted pulse.
`timescale 1ns/1ps
`default_nettype none
module trig_src
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] fire,
   output logic [3:0] pins
);
   logic [2:0] hold_reg [4];
   // Pulses last six clocks so the synchroniser cannot miss them
   always_ff @(posedge clk or negedge rst_b)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (!rst_b)
            hold_reg[i] <= 3'h0;
         else if (fire[i])
            hold_reg[i] <= 3'h6;
         else if (hold_reg[i] != 3'h0)
            hold_reg[i] <= hold_reg[i] - 3'h1;
      end
   end
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         pins[i] = (hold_reg[i] != 3'h0);
   end
endmodule // trig_src
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the timer counter over APB.
// Assumes zero-wait APB slave and registered two-cycle event outputs.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"
module tb_top;
   logic CORE_CLK, RST_B, PSEL, PENABLE, PWRITE, CAPTURE_IN;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, rd;
   logic PREADY, PSLVERR, err, IRQ, WAVE_OUT, WAVE_OUT_INV;
   logic [3:0] ev, fire, pins;
   int n_errors, check_count, cycles, per, wid;
   int exp_per [5] = '{5, 5, 8, 4, 10};
   int exp_cc [5] = '{5, 5, 4, 4, 10};
   int exp_wrap [5] = '{5, 5, 8, 8, 10};
   logic [31:0] ctl_tab [5] = '{32'h0, 32'h1_0000, 32'h2_0000,
      32'h3_0000, 32'h100};

   timer_mode_counter u_dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .TRIG_IN(pins), .CAPTURE_IN(CAPTURE_IN),
      .CC_HIT_OUT(ev[0]), .ZERO_WRAP_OUT(ev[1]), .TOP_WRAP_OUT(ev[2]),
      .TERMINAL_OUT(ev[3]), .IRQ(IRQ), .WAVE_OUT(WAVE_OUT),
      .WAVE_OUT_INV(WAVE_OUT_INV));
   trig_src u_src (.clk(CORE_CLK), .rst_b(RST_B), .fire(fire),
      .pins(pins));

   initial
   begin
      CORE_CLK = 1'b0;
      forever #25 CORE_CLK = ~CORE_CLK;
   end

   task automatic finish_test();
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge CORE_CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits for PREADY without assuming a latency
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cfg(input logic [31:0] ctl);
      apb(1'b1, `OFF_EN_CLR, 32'h1);
      apb(1'b1, `OFF_CTRL, ctl);
      apb(1'b1, `OFF_EN_SET, 32'h1);
      apb(1'b1, `OFF_CMD, 32'h1);
   endtask

   task automatic waitn(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask

   // Width and spacing of the next pulse, sampled away from the edge
   task automatic meas(input int i);
      int n;
      n = 0;
      wid = 0;
      while (ev[i] !== 1'b0 && n < 50)
      begin
         @(negedge CORE_CLK);
         n++;
      end
      while (ev[i] !== 1'b1 && n < 100)
      begin
         @(negedge CORE_CLK);
         n++;
      end
      while (ev[i] === 1'b1 && wid < 20)
      begin
         @(negedge CORE_CLK);
         wid++;
      end
      per = wid;
      while (ev[i] !== 1'b1 && per < 50)
      begin
         @(negedge CORE_CLK);
         per++;
      end
   endtask

   initial
   begin
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      RST_B = 1'b0;
      {PSEL, PENABLE, PWRITE, CAPTURE_IN} = 4'h0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      fire = 4'h0;
      waitn(8);
      RST_B <= 1'b1;
      rchk(`OFF_CTRL, 32'h0);
      rchk(`OFF_TOP, 32'hffff);
      rchk(`OFF_TRSEL, 32'h200);
      rchk(`OFF_TREDGE, 32'h0c0);
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, `OFF_TOP, 32'h4);
      apb(1'b1, `OFF_CMP, 32'h2);
      CAPTURE_IN <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         cfg(ctl_tab[k]);
         meas(3);
         chk(per, exp_per[k]);
         chk(wid, 2);
         meas(0);
         chk(per, exp_cc[k]);
         // Down and mode-three directions watch zero wrap, the rest top wrap
         meas(ctl_tab[k][16] ? 1 : 2);
         chk(per, exp_wrap[k]);
         apb(1'b0, `OFF_COUNT, 32'h0);
         chk(rd <= 32'h4, 1);
      end
      chk({WAVE_OUT, WAVE_OUT_INV}, 2'b00);
      // Single run with compare swap: one hit, then a stop at the wrap
      apb(1'b1, `OFF_CMP_SH, 32'h1);
      apb(1'b1, `OFF_TOP_SH, 32'h1);
      cfg(32'h4_0001);
      apb(1'b1, `OFF_INTR, 32'h3);
      waitn(20);
      rchk(`OFF_STATUS, 32'h0);
      rchk(`OFF_CMP, 32'h1);
      rchk(`OFF_CMP_SH, 32'h2);
      rchk(`OFF_INTR, 32'h3);
      chk(IRQ, 1'b0);
      apb(1'b1, `OFF_INTR_MASK, 32'h1);
      // The mask lands at the edge that ends the write
      waitn(1);
      chk(IRQ, 1'b1);
      rchk(`OFF_INTR_MSKD, 32'h1);
      apb(1'b1, `OFF_INTR, 32'h1);
      rchk(`OFF_INTR_SET, 32'h2);
      chk(IRQ, 1'b0);
      // Stop, hold, continue downwards, ignored start while running
      cfg(32'h0);
      waitn(3);
      apb(1'b1, `OFF_CMD, 32'h4);
      apb(1'b1, `OFF_COUNT, 32'h2);
      waitn(6);
      rchk(`OFF_COUNT, 32'h2);
      rchk(`OFF_STATUS, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h1_0000);
      apb(1'b1, `OFF_CMD, 32'h2);
      rchk(`OFF_STATUS, 32'h3);
      apb(1'b1, `OFF_CTRL, 32'h0);
      apb(1'b1, `OFF_CMD, 32'h2);
      rchk(`OFF_STATUS, 32'h3);
      // Pin triggers: stop on pin 1, start on pin 0
      apb(1'b1, `OFF_TRSEL, 32'h2d0);
      fire <= 4'h2;
      waitn(1);
      fire <= 4'h0;
      waitn(12);
      rchk(`OFF_STATUS, 32'h2);
      fire <= 4'h1;
      waitn(1);
      fire <= 4'h0;
      waitn(12);
      rchk(`OFF_STATUS, 32'h1);
      // Reload waits while the count event is low
      apb(1'b1, `OFF_TRSEL, 32'h0);
      cfg(32'h0);
      apb(1'b1, `OFF_COUNT, 32'h3);
      waitn(6);
      rchk(`OFF_STATUS, 32'h0);
      rchk(`OFF_COUNT, 32'h3);
      apb(1'b1, `OFF_TRSEL, 32'h200);
      waitn(3);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk(rd[0], 1'b1);
      // Non-timer function field refuses the reload
      cfg(32'h100_0000);
      waitn(6);
      rchk(`OFF_STATUS, 32'h0);
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
